// >>> dsea_consts.svh
`ifndef DSEA_CONSTS_SVH
`define DSEA_CONSTS_SVH

// Data space map
`define DSEA_REGS_END     16'h001F
`define DSEA_IO_BASE      16'h0020
`define DSEA_IO_END       16'h005F
`define DSEA_SRAM_BASE    16'h0060
`define DSEA_SRAM_END     16'h045F
`define DSEA_SRAM_BYTES   1024
`define DSEA_SRAM_AW      10
`define DSEA_REG_COUNT    32

// Pointer pairs, low byte index in the register file
`define DSEA_RX_LO        5'h1A
`define DSEA_RY_LO        5'h1C
`define DSEA_RZ_LO        5'h1E

// Nonvolatile store registers, I/O window offsets
`define DSEA_IO_NVM_CTRL  6'h1C
`define DSEA_IO_NVM_DATA  6'h1D
`define DSEA_IO_NVM_ADRL  6'h1E
`define DSEA_IO_NVM_ADRH  6'h1F
`define DSEA_CTL_RD       0
`define DSEA_CTL_WR       1
`define DSEA_CTL_ARM      2
`define DSEA_NVM_BYTES    512
`define DSEA_NVM_AW       9

// Timing
`define DSEA_ARM_CYCLES   3'h4
`define DSEA_RD_STALL     3'h4
`define DSEA_WR_STALL     3'h2
`define DSEA_CLK_HZ       10000000
`define DSEA_NVM_OSC_HZ   1000000
`define DSEA_NVM_WR_OSC   8448
`define DSEA_NVM_OSC_DIV  (`DSEA_CLK_HZ / `DSEA_NVM_OSC_HZ)

`endif

// >>> dsea_pkg.sv
`include "dsea_consts.svh"
package dsea_pkg;

  // Data addressing modes
  typedef enum logic [2:0]
  {
    DSEA_MODE_DIRECT,
    DSEA_MODE_IND,
    DSEA_MODE_DISP,
    DSEA_MODE_PREDEC,
    DSEA_MODE_POSTINC
  } dsea_mode_t;

  // Pointer pair select
  typedef enum logic [1:0]
  {
    DSEA_PTR_X,
    DSEA_PTR_Y,
    DSEA_PTR_Z
  } dsea_ptr_t;

  // One CPU data request
  typedef struct packed
  {
    logic       we;
    dsea_mode_t mode;
    dsea_ptr_t  ptr;
    logic [5:0] disp;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dsea_req_t;

  // Access sequencer
  typedef enum logic [1:0]
  {
    DSEA_ST_IDLE,
    DSEA_ST_ACC,
    DSEA_ST_STALL
  } dsea_state_t;

endpackage

// >>> dsea_sram.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsea_consts.svh"
module dsea_sram
#(
  parameter int DEPTH = `DSEA_SRAM_BYTES,
  parameter int AW    = `DSEA_SRAM_AW
)
(
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic [7:0]         rdata
);

  logic [7:0] mem [DEPTH];

  // Write on the access cycle edge
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
  end

  // Read is combinational so the sequencer captures it in one edge
  assign rdata = mem[addr];

endmodule // dsea_sram
`default_nettype wire

// >>> dsea_nvm_store.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsea_consts.svh"
module dsea_nvm_store
#(
  parameter int DEPTH  = `DSEA_NVM_BYTES,
  parameter int AW     = `DSEA_NVM_AW,
  parameter int OSC_DIV = `DSEA_NVM_OSC_DIV,
  parameter int WR_OSC = `DSEA_NVM_WR_OSC
)
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          start,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic [7:0]         rdata,
  output logic               busy
);

  localparam int DW = (OSC_DIV > 1) ? $clog2(OSC_DIV) : 1;
  localparam int TW = $clog2(WR_OSC + 1);

  logic [7:0]    mem [DEPTH];
  logic [DW-1:0] div_ff;
  logic [TW-1:0] tick_ff;
  logic [AW-1:0] cap_addr_ff;
  logic [7:0]    cap_data_ff;
  logic          busy_ff;
  logic          osc_tick;
  logic          done;

  // Oscillator tick derived from the CPU clock, only while writing
  assign osc_tick = busy_ff && (div_ff == DW'(OSC_DIV - 1));
  assign done     = osc_tick && (tick_ff == TW'(WR_OSC - 1));
  assign busy     = busy_ff;
  assign rdata    = mem[addr];

  // Divider and write timer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div_ff  <= '0;
      tick_ff <= '0;
      busy_ff <= 1'b0;
    end
    else if (!busy_ff)
    begin
      div_ff  <= '0;
      tick_ff <= '0;
      busy_ff <= start;
    end
    else
    begin
      div_ff  <= osc_tick ? '0 : div_ff + DW'(1);
      tick_ff <= osc_tick ? tick_ff + TW'(1) : tick_ff;
      busy_ff <= !done;
    end
  end

  // Latch target at start; later register writes cannot disturb it
  always_ff @(posedge clk)
  begin
    if (start && !busy_ff)
    begin
      cap_addr_ff <= addr;
      cap_data_ff <= wdata;
    end
    if (done)
    begin
      mem[cap_addr_ff] <= cap_data_ff;
    end
  end

endmodule // dsea_nvm_store
`default_nettype wire

// >>> dsea_data_space.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsea_consts.svh"
module dsea_data_space
  import dsea_pkg::*;
#(
  parameter int NVM_WR_OSC  = `DSEA_NVM_WR_OSC,
  parameter int NVM_OSC_DIV = `DSEA_NVM_OSC_DIV
)
(
  input  wire logic      CLK,
  input  wire logic      RST,
  input  wire logic      REQ_VALID,
  input  wire dsea_req_t REQ,
  output logic           BUSY,
  output logic           RSP_VALID,
  output logic [7:0]     RSP_RDATA
);

  // Register file and access state
  logic [7:0]   rf [`DSEA_REG_COUNT];
  dsea_state_t  state_ff;
  logic         busy_ff;
  logic         rsp_valid_ff;
  logic [7:0]   rdata_ff;
  logic [15:0]  addr_ff;
  logic         we_ff;
  logic [7:0]   wdata_ff;
  logic [2:0]   stall_ff;

  // Nonvolatile store registers
  logic [8:0]   nvm_addr_ff;
  logic [7:0]   nvm_data_ff;
  logic [2:0]   arm_ff;
  logic         nvm_busy;
  logic [7:0]   nvm_rdata;

  // Request decode wires
  logic         take;
  logic [4:0]   ptr_lo;
  logic [4:0]   ptr_hi;
  logic [15:0]  ptr_val;
  logic [15:0]  ptr_dec;
  logic [15:0]  ptr_inc;
  logic [15:0]  disp_ext;
  logic [15:0]  eff_addr;
  logic         ptr_upd;
  logic [15:0]  ptr_new;

  // Access decode wires
  logic         in_acc;
  logic         hit_rf;
  logic         hit_io;
  logic         hit_sram;
  logic [15:0]  io_off;
  logic [5:0]   io_idx;
  logic [15:0]  sram_off;
  logic [9:0]   sram_idx;
  logic [7:0]   sram_rdata;
  logic         sram_we;
  logic         io_we;
  logic         ctl_wr;
  logic         data_wr;
  logic         adrl_wr;
  logic         adrh_wr;
  logic         arm_on;
  logic         wr_start;
  logic         rd_go;
  logic [7:0]   ctl_val;
  logic [7:0]   io_rdata;
  logic [7:0]   rd_mux;
  logic [2:0]   nxt_arm;

  assign take = REQ_VALID && !busy_ff;

  // Pointer selection; X, Y and Z live in the top six registers
  assign ptr_lo = (REQ.ptr == DSEA_PTR_X) ? `DSEA_RX_LO :
                  (REQ.ptr == DSEA_PTR_Y) ? `DSEA_RY_LO :
                                            `DSEA_RZ_LO;
  assign ptr_hi  = ptr_lo + 5'h01;
  assign ptr_val = {rf[ptr_hi], rf[ptr_lo]};
  assign ptr_dec = ptr_val - 16'h0001;
  assign ptr_inc = ptr_val + 16'h0001;

  // Displacement only exists for Y and Z; X ignores the field
  assign disp_ext = (REQ.mode == DSEA_MODE_DISP && REQ.ptr != DSEA_PTR_X)
                  ? {10'h000, REQ.disp} : 16'h0000;

  // Effective address for each addressing mode
  assign eff_addr = (REQ.mode == DSEA_MODE_DIRECT) ? REQ.addr :
                    (REQ.mode == DSEA_MODE_PREDEC) ? ptr_dec :
                    ptr_val + disp_ext;

  // Pointer writeback: decremented before use, incremented after
  assign ptr_upd = take && (REQ.mode == DSEA_MODE_PREDEC ||
                            REQ.mode == DSEA_MODE_POSTINC);
  assign ptr_new = (REQ.mode == DSEA_MODE_PREDEC) ? ptr_dec
                                                  : ptr_inc;

  // Region decode of the held address
  assign in_acc   = (state_ff == DSEA_ST_ACC);
  assign hit_rf   = (addr_ff <= `DSEA_REGS_END);
  assign hit_io   = (addr_ff >= `DSEA_IO_BASE) &&
                    (addr_ff <= `DSEA_IO_END);
  assign hit_sram = (addr_ff >= `DSEA_SRAM_BASE) &&
                    (addr_ff <= `DSEA_SRAM_END);
  assign io_off   = addr_ff - `DSEA_IO_BASE;
  assign io_idx   = io_off[5:0];
  assign sram_off = addr_ff - `DSEA_SRAM_BASE;
  assign sram_idx = sram_off[9:0];

  // Write strobes; anything above the SRAM simply drops
  assign sram_we = in_acc && we_ff && hit_sram;
  assign io_we   = in_acc && we_ff && hit_io;
  assign ctl_wr  = io_we && (io_idx == `DSEA_IO_NVM_CTRL);
  assign data_wr = io_we && (io_idx == `DSEA_IO_NVM_DATA);
  assign adrl_wr = io_we && (io_idx == `DSEA_IO_NVM_ADRL) &&
                   !nvm_busy;
  assign adrh_wr = io_we && (io_idx == `DSEA_IO_NVM_ADRH) &&
                   !nvm_busy;

  // Strobe qualification; an unarmed write strobe does nothing
  assign arm_on   = (arm_ff != 3'h0);
  assign wr_start = ctl_wr && wdata_ff[`DSEA_CTL_WR] && arm_on &&
                    !nvm_busy;
  assign rd_go    = ctl_wr && wdata_ff[`DSEA_CTL_RD] && !nvm_busy &&
                    !wr_start;

  // Control readback: strobe shows write in progress
  assign ctl_val = {5'h00, arm_on, nvm_busy, 1'b0};

  // I/O read selection; other I/O slots belong elsewhere, read zero
  assign io_rdata =
    (io_idx == `DSEA_IO_NVM_CTRL) ? ctl_val :
    (io_idx == `DSEA_IO_NVM_DATA) ? nvm_data_ff :
    (io_idx == `DSEA_IO_NVM_ADRL) ? nvm_addr_ff[7:0] :
    (io_idx == `DSEA_IO_NVM_ADRH) ? {7'h00, nvm_addr_ff[8]} :
    8'h00;

  // Data space read selection
  assign rd_mux = hit_rf   ? rf[addr_ff[4:0]] :
                  hit_io   ? io_rdata :
                  hit_sram ? sram_rdata :
                  8'h00;

  // Arm timeout counts down from the arming write
  assign nxt_arm = (ctl_wr && wdata_ff[`DSEA_CTL_ARM]) ? `DSEA_ARM_CYCLES :
                   arm_on ? arm_ff - 3'h1 : 3'h0;

  // Internal SRAM
  dsea_sram
  #(
    .DEPTH (`DSEA_SRAM_BYTES),
    .AW    (`DSEA_SRAM_AW)
  )
  u_sram
  (
    .clk   (CLK),
    .we    (sram_we),
    .addr  (sram_idx),
    .wdata (wdata_ff),
    .rdata (sram_rdata)
  );

  // Nonvolatile byte store with its own write timer
  dsea_nvm_store
  #(
    .DEPTH   (`DSEA_NVM_BYTES),
    .AW      (`DSEA_NVM_AW),
    .OSC_DIV (NVM_OSC_DIV),
    .WR_OSC  (NVM_WR_OSC)
  )
  u_nvm
  (
    .clk   (CLK),
    .rst   (RST),
    .start (wr_start),
    .addr  (nvm_addr_ff),
    .wdata (nvm_data_ff),
    .rdata (nvm_rdata),
    .busy  (nvm_busy)
  );

  // Register file: pointer update on take, data write on access
  always_ff @(posedge CLK)
  begin
    if (ptr_upd)
    begin
      rf[ptr_lo] <= ptr_new[7:0];
      rf[ptr_hi] <= ptr_new[15:8];
    end
    else if (in_acc && we_ff && hit_rf)
    begin
      rf[addr_ff[4:0]] <= wdata_ff;
    end
  end

  // Request capture
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      addr_ff  <= 16'h0000;
      we_ff    <= 1'b0;
      wdata_ff <= 8'h00;
    end
    else if (take)
    begin
      addr_ff  <= eff_addr;
      we_ff    <= REQ.we;
      wdata_ff <= REQ.wdata;
    end
  end

  // Access sequencer: take, one access cycle, optional stall
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      state_ff     <= DSEA_ST_IDLE;
      busy_ff      <= 1'b0;
      rsp_valid_ff <= 1'b0;
      rdata_ff     <= 8'h00;
      stall_ff     <= 3'h0;
    end
    else
    begin
      rsp_valid_ff <= 1'b0;
      case (state_ff)
        DSEA_ST_IDLE:
        begin
          if (take)
          begin
            state_ff <= DSEA_ST_ACC;
            busy_ff  <= 1'b1;
          end
        end
        DSEA_ST_ACC:
        begin
          rsp_valid_ff <= 1'b1;
          if (!we_ff)
          begin
            rdata_ff <= rd_mux;
          end
          if (wr_start)
          begin
            state_ff <= DSEA_ST_STALL;
            stall_ff <= `DSEA_WR_STALL;
          end
          else if (rd_go)
          begin
            state_ff <= DSEA_ST_STALL;
            stall_ff <= `DSEA_RD_STALL;
          end
          else
          begin
            state_ff <= DSEA_ST_IDLE;
            busy_ff  <= 1'b0;
          end
        end
        DSEA_ST_STALL:
        begin
          stall_ff <= stall_ff - 3'h1;
          if (stall_ff == 3'h1)
          begin
            state_ff <= DSEA_ST_IDLE;
            busy_ff  <= 1'b0;
          end
        end
        default:
        begin
          state_ff <= DSEA_ST_IDLE;
          busy_ff  <= 1'b0;
        end
      endcase
    end
  end

  // Store registers; address frozen while a write runs
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      nvm_addr_ff <= 9'h000;
      nvm_data_ff <= 8'h00;
      arm_ff      <= 3'h0;
    end
    else
    begin
      arm_ff <= nxt_arm;
      if (adrl_wr)
      begin
        nvm_addr_ff[7:0] <= wdata_ff;
      end
      if (adrh_wr)
      begin
        nvm_addr_ff[8] <= wdata_ff[0];
      end
      // Read result lands before the CPU resumes
      if (rd_go)
      begin
        nvm_data_ff <= nvm_rdata;
      end
      else if (data_wr)
      begin
        nvm_data_ff <= wdata_ff;
      end
    end
  end

  // Outputs straight from flops
  assign BUSY      = busy_ff;
  assign RSP_VALID = rsp_valid_ff;
  assign RSP_RDATA = rdata_ff;

endmodule // dsea_data_space
`default_nettype wire

// >>> dsea_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module dsea_cpu_model
  import dsea_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       BUSY,
  input  wire logic       RSP_VALID,
  input  wire logic [7:0] RSP_RDATA,
  output logic            REQ_VALID,
  output dsea_req_t       REQ
);
  // Idle bus at time zero
  initial
  begin
    REQ_VALID = 1'b0;
    REQ       = '0;
  end

  // One access; n counts edges from take until busy drops
  task automatic xfer(input dsea_req_t r, output logic [7:0] d,
                      output int n);
    n = 0;
    d = 8'h00;
    @(posedge CLK);
    #1;
    REQ_VALID = 1'b1;
    REQ       = r;
    // Held until an edge that sees busy low
    while (BUSY !== 1'b0)
    begin
      @(posedge CLK);
      #1;
    end
    @(posedge CLK);
    #1;
    REQ_VALID = 1'b0;
    REQ       = ~r; // Stale fields never look valid
    do
    begin
      @(posedge CLK);
      #1;
      n++;
      if (RSP_VALID === 1'b1)
        d = RSP_RDATA;
    end while (BUSY !== 1'b0 && n < 100);
  endtask
endmodule // dsea_cpu_model
`default_nettype wire

// >>> dsea_data_space_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dsea_data_space_assertions
  import dsea_pkg::*;
#(
  parameter int NVM_WR_OSC  = 8448,
  parameter int NVM_OSC_DIV = 10
)
(
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic       REQ_VALID,
  input wire dsea_req_t  REQ,
  input wire logic       BUSY,
  input wire logic       RSP_VALID,
  input wire logic [7:0] RSP_RDATA
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  // Takes sorted by kind; store strobes decoded from the control write value alone
  wire take   = REQ_VALID && !BUSY;
  wire dir    = take && REQ.mode == DSEA_MODE_DIRECT;
  wire ctl_w  = dir && REQ.we && REQ.addr == 16'h003C;
  wire rd_stb = ctl_w && REQ.wdata == 8'h01;
  wire arm    = ctl_w && REQ.wdata == 8'h04;
  wire wr_stb = ctl_w && REQ.wdata == 8'h02;
  wire plain  = take && !ctl_w;
  wire hi_rd  = dir && !REQ.we && REQ.addr > 16'h045F;
  wire ah_rd  = dir && !REQ.we && REQ.addr == 16'h003F;

  sequence s_armed_strobe;
    arm ##3 wr_stb;
  endsequence

  AST_TAKE_BUSY: assert property (take |=> BUSY)
    else $error("busy not raised after take");
  AST_PLAIN_TWO: assert property (plain |=> BUSY ##1 !BUSY)
    else $error("plain access not two cycles");
  AST_RSP_CAUSE: assert property (RSP_VALID |-> $past(take, 2))
    else $error("response without take");
  AST_RSP_PULSE: assert property (RSP_VALID |=> !RSP_VALID)
    else $error("response longer than one cycle");
  AST_RD_STALL: assert property (rd_stb |=> BUSY [*5] ##1 !BUSY)
    else $error("read strobe stall wrong");
  AST_WR_STALL: assert property (s_armed_strobe |=> BUSY [*3] ##1 !BUSY)
    else $error("write start stall wrong");
  AST_HI_ZERO: assert property (hi_rd |=> ##1 RSP_RDATA == 8'h00)
    else $error("read above map not zero");
  AST_ADRH_ZERO: assert property (ah_rd |=> ##1 RSP_RDATA[7:1] == 7'h00)
    else $error("address high spare bits not zero");
  AST_WR_HOLD: assert property (take && REQ.we |=> ##1 $stable(RSP_RDATA))
    else $error("read data moved on a write");
endmodule // dsea_data_space_assertions
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench import dsea_pkg::*;;
  // Short store write: 40 ticks of 2 clocks keeps the run brief
  localparam int WR_OSC  = 40;
  localparam int OSC_DIV = 2;
  logic       CLK = 1'b0;
  logic       RST = 1'b1;
  logic       REQ_VALID;
  logic       BUSY;
  logic       RSP_VALID;
  logic [7:0] RSP_RDATA;
  dsea_req_t  REQ;
  int         n_fail = 0;
  int         comparisons = 0;
  int         cycles = 0;
  int         n;
  logic [7:0] d;
  logic [15:0] adr [6] = '{16'h0000, 16'h001F, 16'h0060, 16'h045F,
                           16'h0021, 16'h0460};

  dsea_data_space #(.NVM_WR_OSC(WR_OSC), .NVM_OSC_DIV(OSC_DIV)) dut_u
  (
    .CLK       (CLK),
    .RST       (RST),
    .REQ_VALID (REQ_VALID),
    .REQ       (REQ),
    .BUSY      (BUSY),
    .RSP_VALID (RSP_VALID),
    .RSP_RDATA (RSP_RDATA)
  );

  dsea_cpu_model cpu_u
  (
    .CLK       (CLK),
    .BUSY      (BUSY),
    .RSP_VALID (RSP_VALID),
    .RSP_RDATA (RSP_RDATA),
    .REQ_VALID (REQ_VALID),
    .REQ       (REQ)
  );

  always #50 CLK = ~CLK;

  // Hang guard, well above the expected run
  always @(posedge CLK)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      summarize();
    end
  end

  task automatic summarize();
    if (n_fail == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    cpu_u.xfer({1'b1, DSEA_MODE_DIRECT, DSEA_PTR_X, 6'h00, a, v}, d, n);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    cpu_u.xfer({1'b0, DSEA_MODE_DIRECT, DSEA_PTR_X, 6'h00, a, 8'h00}, d, n);
    cmp(d, e);
  endtask

  task automatic prd(input dsea_mode_t m, input dsea_ptr_t p,
                     input logic [5:0] o, input logic [7:0] e);
    cpu_u.xfer({1'b0, m, p, o, 16'h0000, 8'h00}, d, n);
    cmp(d, e);
  endtask

  // Address first, then data, then arm and strobe
  task automatic nvm_wr(input logic [8:0] a, input logic [7:0] v);
    wr(16'h003E, a[7:0]);
    wr(16'h003F, {7'h00, a[8]});
    wr(16'h003D, v);
    wr(16'h003C, 8'h04);
    wr(16'h003C, 8'h02);
    cmp(8'(n), 8'h03);
  endtask

  task automatic nvm_rd(input logic [8:0] a, input logic [7:0] e);
    wr(16'h003E, a[7:0]);
    wr(16'h003F, {7'h00, a[8]});
    wr(16'h003C, 8'h01);
    cmp(8'(n), 8'h05);
    rd(16'h003D, e);
  endtask

  // Poll the busy bit, bounded
  task automatic nvm_wait();
    int k = 0;
    do
    begin
      wr(16'h0000, RSP_RDATA);
      rd(16'h0000, RSP_RDATA);
      cpu_u.xfer({1'b0, DSEA_MODE_DIRECT, DSEA_PTR_X, 6'h00, 16'h003C,
                  8'h00}, d, n);
      k++;
    end while (d[1] !== 1'b0 && k < 60);
    cmp(d, 8'h00);
  endtask

  initial
  begin
    repeat (6) @(posedge CLK);
    #1;
    RST = 1'b0;
    // Both ends of registers and SRAM, I/O hole and space above the map
    foreach (adr[i])
      wr(adr[i], 8'hA0 + 8'(i));
    foreach (adr[i])
    begin
      rd(adr[i], i < 4 ? 8'hA0 + 8'(i) : 8'h00);
      cmp(8'(n), 8'h01);
    end
    // Pointer modes through Y, X and Z
    wr(16'h001C, 8'h60);
    wr(16'h001D, 8'h00);
    wr(16'h009F, 8'h5C);
    prd(DSEA_MODE_DISP, DSEA_PTR_Y, 6'h3F, 8'h5C);
    prd(DSEA_MODE_POSTINC, DSEA_PTR_Y, 6'h00, 8'hA2);
    rd(16'h001C, 8'h61);
    prd(DSEA_MODE_PREDEC, DSEA_PTR_Y, 6'h00, 8'hA2);
    rd(16'h001C, 8'h60);
    wr(16'h001A, 8'h5F);
    wr(16'h001B, 8'h04);
    prd(DSEA_MODE_IND, DSEA_PTR_X, 6'h00, 8'hA3);
    wr(16'h001E, 8'h00);
    wr(16'h001F, 8'h00);
    prd(DSEA_MODE_IND, DSEA_PTR_Z, 6'h00, 8'hA0);
    // Store write, then tamper with registers while it runs
    nvm_wr(9'h134, 8'hA5);
    rd(16'h003C, 8'h02);
    wr(16'h003E, 8'h00);
    wr(16'h003D, 8'h5A);
    rd(16'h003E, 8'h34);
    nvm_wait();
    nvm_wr(9'h1FF, 8'h3C);
    nvm_wait();
    nvm_rd(9'h134, 8'hA5);
    nvm_rd(9'h1FF, 8'h3C);
    wr(16'h003F, 8'hFF);
    rd(16'h003F, 8'h01);
    // Strobe without arm, then after the arm has lapsed
    wr(16'h003C, 8'h02);
    cmp(8'(n), 8'h01);
    wr(16'h003C, 8'h04);
    rd(16'h003C, 8'h04);
    wr(16'h003C, 8'h02);
    cmp(8'(n), 8'h01);
    rd(16'h003C, 8'h00);
    summarize();
  end
endmodule // testbench

bind dsea_data_space dsea_data_space_assertions
  #(.NVM_WR_OSC(NVM_WR_OSC), .NVM_OSC_DIV(NVM_OSC_DIV)) chk_u
(
  .CLK       (CLK),
  .RST       (RST),
  .REQ_VALID (REQ_VALID),
  .REQ       (REQ),
  .BUSY      (BUSY),
  .RSP_VALID (RSP_VALID),
  .RSP_RDATA (RSP_RDATA)
);
`default_nettype wire
